// ### verilog/crs_slots.sv
// sixteen message slots armed for remote-frame reception with automatic reply
// assumes a can engine giving one-cycle rx_done/tx outcome pulses, apb master, free-running time stamp
//
// Notes on behaviour
// (RQ1) writing 0x60 or 0x70 to a slot control register sets remote active
// (RQ2) after a frame, search slots from 0 up to 15 for a match
// (RQ3) a remote-armed slot accepts only remote frames
// (RQ4) id compared bit by bit, mask zero bits are don't care
// (RQ5) frame format must equal the slot's configured format
// (RQ6) on match set in-progress and finished while storing the frame
// (RQ7) time stamp counter value at reception stored with the frame
// (RQ8) after storing set slot interrupt status and request if enabled
// (RQ9) accepted remote frame stores identifier and dlc into the slot
// (RQ10) standard frame may leave extended id undefined, data never written
// (RQ11) after storing, clear remote active and finished flags
// (RQ12) no matching slot: frame discarded, nothing written
// (RQ13) reply inhibited: slot goes inactive until software rearms it
// (RQ14) reply enabled: slot becomes data transmit slot with received id and dlc
// (RQ15) each intermission the lowest numbered pending slot is sent first
// (RQ16) arbitration loss or bus error clears in-progress
// (RQ17) pending abort is accepted on loss or error, slot writable again
// (RQ18) reply sent: set finished and interrupt status, store time stamp
// (RQ19) after reply, interrupt if enabled, slot held inactive
// (RQ20) software arms with 0x60, or 0x70 to inhibit reply
// (RQ21) software writes 0x00 and waits for in-progress low before id setup
// (RQ22) basic mailbox mode: slots 14 and 15 never send automatic reply
// (RQ23) search and slot writes end well before the next frame end
// (RQ24) stored time stamps sampled from a free-running counter input
`timescale 1ns/1ns
module crs_slots import crs_pkg::*; #(
  parameter int N = 16,
  parameter int TS_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received frame from the can engine
  input wire logic rx_done,
  input wire logic rx_remote,
  input wire logic rx_ext,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic [DLC_W-1:0] rx_dlc,
  // transmit request to the can engine
  input wire logic tx_intermission,
  input wire logic tx_done,
  input wire logic tx_arb_lost,
  input wire logic tx_bus_err,
  output logic tx_valid,
  output logic [SLOT_IDX_W-1:0] tx_slot,
  output logic [ID_W-1:0] tx_id,
  output logic tx_ext,
  output logic [DLC_W-1:0] tx_dlc,
  // time stamp and interrupt
  input wire logic [TS_W-1:0] ts_count,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] tr;
    logic [N-1:0] rr;
    logic [N-1:0] rm;
    logic [N-1:0] rl;
    logic [N-1:0] ra;
    logic [N-1:0] xip;
    logic [N-1:0] fin;
    logic [N-1:0] abt;
    logic [N-1:0] ext;
    logic [N-1:0][ID_W-1:0] id;
    logic [N-1:0][DLC_W-1:0] dlc;
    logic [N-1:0][TS_W-1:0] ts;
    logic [N-1:0] int_status;
    logic [N-1:0] int_en;
    logic [ID_W-1:0] mask;
    logic basic;
    crs_rx_t rx_st;
    logic [SLOT_IDX_W-1:0] cur;
    logic tx_valid;
    logic [SLOT_IDX_W-1:0] tx_slot;
    logic [ID_W-1:0] tx_id;
    logic tx_ext;
    logic [DLC_W-1:0] tx_dlc;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } crs_state_t;

  crs_state_t s;
  crs_state_t next_s;

  logic [N-1:0] hit;
  logic hit_any;
  logic [SLOT_IDX_W-1:0] hit_idx;
  logic [N-1:0] pend;
  logic pend_any;
  logic [SLOT_IDX_W-1:0] pend_idx;
  logic [SLOT_IDX_W-1:0] aslot;
  logic in_slot;
  logic addr_ok;
  logic [31:0] rd_data;
  logic apb_wr;
  logic wr_ctrl;

  assign aslot = paddr[7:4];
  assign in_slot = (paddr < GLB_BASE) && (int'(aslot) < N);
  assign apb_wr = psel & penable & s.pready & pwrite & addr_ok;
  assign wr_ctrl = apb_wr & in_slot & (paddr[3:2] == SLOT_CTRL);

  // acceptance filter and transmit selection, lowest slot wins
  always_comb begin
    hit = '0;
    pend = '0;
    hit_idx = '0;
    pend_idx = '0;
    for (int i = 0; i < N; i++) begin
      hit[i] = s.rr[i] & s.rm[i] & ~s.tr[i] & rx_remote // RQ3
        & (((s.id[i] ^ rx_id) & s.mask) == '0) // RQ4
        & (s.ext[i] == rx_ext); // RQ5
      pend[i] = s.tr[i] & ~s.xip[i] & ~(s.basic & (i >= N - 2)); // RQ22
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = SLOT_IDX_W'(i); // RQ2
      end
      if (pend[i]) begin
        pend_idx = SLOT_IDX_W'(i); // RQ15
      end
    end
    hit_any = |hit;
    pend_any = |pend;
  end

  // register read mux and address check
  always_comb begin
    rd_data = RD_ZERO;
    addr_ok = 1'b1;
    if (in_slot) begin
      case (paddr[3:2])
        SLOT_CTRL: begin
          rd_data[CTL_TR] = s.tr[aslot];
          rd_data[CTL_RR] = s.rr[aslot];
          rd_data[CTL_RM] = s.rm[aslot];
          rd_data[CTL_RL] = s.rl[aslot];
          rd_data[CTL_RA] = s.ra[aslot];
          rd_data[CTL_XIP] = s.xip[aslot];
          rd_data[CTL_FIN] = s.fin[aslot];
          rd_data[CTL_ABT] = s.abt[aslot];
        end
        SLOT_ID: begin
          rd_data[ID_W-1:0] = s.id[aslot];
          rd_data[ID_EXT_BIT] = s.ext[aslot];
        end
        SLOT_DLC: rd_data[DLC_W-1:0] = s.dlc[aslot];
        SLOT_TS: rd_data[TS_W-1:0] = s.ts[aslot];
        default: addr_ok = 1'b0;
      endcase
    end else begin
      case (paddr)
        GLB_MASK: rd_data[ID_W-1:0] = s.mask;
        GLB_INT_STAT: rd_data[N-1:0] = s.int_status;
        GLB_INT_EN: rd_data[N-1:0] = s.int_en;
        GLB_CFG: rd_data[CFG_BASIC_BIT] = s.basic;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    // apb: one wait state, write lands on the pready edge
    next_s.pready = psel & penable & ~s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata = RD_ZERO;
    if (psel & penable & ~s.pready) begin
      next_s.pslverr = ~addr_ok;
      if (!pwrite) begin
        next_s.prdata = rd_data;
      end
    end
    if (apb_wr) begin
      if (in_slot) begin
        case (paddr[3:2])
          SLOT_CTRL: begin
            if (s.tx_valid && s.tx_slot == aslot) begin
              // slot on the bus: only an abort request is taken
              next_s.abt[aslot] = pwdata[CTL_ABT];
            end else begin
              next_s.tr[aslot] = pwdata[CTL_TR];
              next_s.rr[aslot] = pwdata[CTL_RR];
              next_s.rm[aslot] = pwdata[CTL_RM];
              next_s.rl[aslot] = pwdata[CTL_RL];
              next_s.ra[aslot] = pwdata[CTL_RM] & (pwdata[CTL_RR] | pwdata[CTL_TR]); // RQ1
              next_s.fin[aslot] = s.fin[aslot] & pwdata[CTL_FIN];
              next_s.abt[aslot] = 1'b0;
            end
          end
          SLOT_ID: begin
            next_s.id[aslot] = pwdata[ID_W-1:0];
            next_s.ext[aslot] = pwdata[ID_EXT_BIT];
          end
          SLOT_DLC: next_s.dlc[aslot] = pwdata[DLC_W-1:0];
          default: next_s.ts[aslot] = s.ts[aslot];
        endcase
      end else begin
        case (paddr)
          GLB_MASK: next_s.mask = pwdata[ID_W-1:0];
          GLB_INT_STAT: next_s.int_status = s.int_status & ~pwdata[N-1:0];
          GLB_INT_EN: next_s.int_en = pwdata[N-1:0];
          GLB_CFG: next_s.basic = pwdata[CFG_BASIC_BIT];
          default: next_s.mask = s.mask;
        endcase
      end
    end
    // receive path; hardware updates follow the bus so that hardware sets and clears win over writes
    case (s.rx_st)
      RX_IDLE: begin
        if (rx_done && hit_any) begin // RQ12
          next_s.id[hit_idx] = rx_id; // RQ9 RQ10
          next_s.ext[hit_idx] = rx_ext;
          next_s.dlc[hit_idx] = rx_dlc; // RQ9
          next_s.ts[hit_idx] = ts_count; // RQ7 RQ24
          next_s.xip[hit_idx] = 1'b1; // RQ6
          next_s.fin[hit_idx] = 1'b1; // RQ6
          next_s.cur = hit_idx;
          next_s.rx_st = RX_WRAP; // RQ23
        end
      end
      RX_WRAP: begin
        next_s.ra[s.cur] = 1'b0; // RQ11
        next_s.fin[s.cur] = 1'b0; // RQ11
        next_s.xip[s.cur] = 1'b0;
        next_s.int_status[s.cur] = 1'b1; // RQ8
        next_s.rr[s.cur] = 1'b0;
        next_s.rm[s.cur] = 1'b0;
        if (!s.rl[s.cur] && !(s.basic && int'(s.cur) >= N - 2)) begin
          next_s.tr[s.cur] = 1'b1; // RQ14 RQ22
        end // else RQ13
        next_s.rx_st = RX_IDLE;
      end
      default: next_s.rx_st = RX_IDLE;
    endcase
    // transmit path
    if (s.tx_valid) begin
      if (tx_done) begin
        next_s.fin[s.tx_slot] = 1'b1; // RQ18
        next_s.int_status[s.tx_slot] = 1'b1; // RQ18
        next_s.ts[s.tx_slot] = ts_count; // RQ18 RQ24
        next_s.tr[s.tx_slot] = 1'b0; // RQ19
        next_s.rr[s.tx_slot] = 1'b0;
        next_s.rm[s.tx_slot] = 1'b0;
        next_s.xip[s.tx_slot] = 1'b0;
        next_s.abt[s.tx_slot] = 1'b0;
        next_s.tx_valid = 1'b0;
      end else if (tx_arb_lost || tx_bus_err) begin
        next_s.xip[s.tx_slot] = 1'b0; // RQ16
        next_s.tx_valid = 1'b0;
        if (s.abt[s.tx_slot] || next_s.abt[s.tx_slot]) begin
          next_s.tr[s.tx_slot] = 1'b0; // RQ17
          next_s.abt[s.tx_slot] = 1'b0;
        end
      end
    end else if (tx_intermission && pend_any) begin
      next_s.tx_valid = 1'b1; // RQ15
      next_s.tx_slot = pend_idx;
      next_s.tx_id = s.id[pend_idx]; // RQ14
      next_s.tx_ext = s.ext[pend_idx];
      next_s.tx_dlc = s.dlc[pend_idx];
      next_s.xip[pend_idx] = 1'b1;
    end
    next_s.irq = |(next_s.int_status & next_s.int_en); // RQ8 RQ19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mask <= MASK_RST;
      s.rx_st <= RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign tx_valid = s.tx_valid;
  assign tx_slot = s.tx_slot;
  assign tx_id = s.tx_id;
  assign tx_ext = s.tx_ext;
  assign tx_dlc = s.tx_dlc;
  assign irq = s.irq;

  a_arm_sets_ra: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    wr_ctrl && !(s.tx_valid && s.tx_slot == aslot)
      && (pwdata[7:0] == ARM_REPLY || pwdata[7:0] == ARM_NO_REPLY)
      && !(s.rx_st == RX_WRAP && s.cur == aslot)
    |=> s.ra[$past(aslot)] && s.rr[$past(aslot)])
    else $error("arming code did not set remote active");

  a_lowest_match: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    rx_done && hit_any && s.rx_st == RX_IDLE
    |-> hit[hit_idx] && ((hit & ((N'(1) << hit_idx) - N'(1))) == '0))
    else $error("matched slot is not the lowest match");

  a_filter_match: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    rx_done && hit_any
    |-> (((s.id[hit_idx] ^ rx_id) & s.mask) == '0) && s.ext[hit_idx] == rx_ext && rx_remote)
    else $error("accepted frame fails the filter");

  a_data_refused: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    rx_done && !rx_remote && s.rx_st == RX_IDLE |=> s.rx_st == RX_IDLE)
    else $error("data frame accepted by a remote slot");

  a_store_frame: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    rx_done && hit_any && s.rx_st == RX_IDLE
    |=> s.ts[s.cur] == $past(ts_count) && s.dlc[s.cur] == $past(rx_dlc)
      && s.id[s.cur] == $past(rx_id) && s.fin[s.cur] && s.xip[s.cur])
    else $error("received frame not stored with its time stamp");

  a_rx_wrap_up: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    s.rx_st == RX_WRAP
    |=> !s.ra[$past(s.cur)] && !s.fin[$past(s.cur)] && s.int_status[$past(s.cur)]
      && s.rx_st == RX_IDLE)
    else $error("slot flags wrong after remote reception");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    s.irq == |(s.int_status & s.int_en))
    else $error("interrupt does not follow enabled status");

  a_basic_no_reply: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
    s.tx_valid |-> !(s.basic && int'(s.tx_slot) >= N - 2))
    else $error("basic mode slot sent an automatic reply");

  a_tx_lowest: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    !s.tx_valid && tx_intermission && pend_any
    |=> s.tx_valid && s.xip[s.tx_slot] && s.tx_id == s.id[s.tx_slot]
      && ($past(pend) & ((N'(1) << s.tx_slot) - N'(1))) == '0)
    else $error("transmit did not pick the lowest pending slot");

  a_tx_fail_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    s.tx_valid && !tx_done && (tx_arb_lost || tx_bus_err)
    |=> !s.xip[$past(s.tx_slot)] && !s.tx_valid)
    else $error("in-progress not cleared after lost transmit");

  a_tx_complete: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    s.tx_valid && tx_done
    |=> s.fin[$past(s.tx_slot)] && s.int_status[$past(s.tx_slot)] && !s.tr[$past(s.tx_slot)]
      && s.ts[$past(s.tx_slot)] == $past(ts_count))
    else $error("reply completion not recorded");

  a_no_match_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    rx_done && !hit_any && s.rx_st == RX_IDLE && !apb_wr && !(s.tx_valid && tx_done)
    |=> s.rx_st == RX_IDLE && s.int_status == $past(s.int_status))
    else $error("unmatched frame changed slot state");

  a_inhibit_idle: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    s.rx_st == RX_WRAP && s.rl[s.cur] && !wr_ctrl
    |=> !s.tr[$past(s.cur)] && !s.rr[$past(s.cur)] && !s.rm[$past(s.cur)])
    else $error("reply-inhibited slot did not go inactive");

  a_reply_armed: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    s.rx_st == RX_WRAP && !s.rl[s.cur] && !s.basic
    |=> s.tr[$past(s.cur)])
    else $error("reply slot not turned into a transmit slot");

endmodule // crs_slots

// ### common/crs_pkg.sv
// constants for the remote-frame receive slot block
// assumes an apb master and a can protocol engine outside the block
package crs_pkg;
  // apb map, byte addresses
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] SLOT_STRIDE = 12'h010;
  localparam logic [1:0] SLOT_CTRL = 2'h0;
  localparam logic [1:0] SLOT_ID = 2'h1;
  localparam logic [1:0] SLOT_DLC = 2'h2;
  localparam logic [1:0] SLOT_TS = 2'h3;
  localparam logic [APB_AW-1:0] GLB_BASE = 12'h100;
  localparam logic [APB_AW-1:0] GLB_MASK = 12'h100;
  localparam logic [APB_AW-1:0] GLB_INT_STAT = 12'h104;
  localparam logic [APB_AW-1:0] GLB_INT_EN = 12'h108;
  localparam logic [APB_AW-1:0] GLB_CFG = 12'h10c;
  // slot control register bit positions
  localparam int CTL_TR = 7;
  localparam int CTL_RR = 6;
  localparam int CTL_RM = 5;
  localparam int CTL_RL = 4;
  localparam int CTL_RA = 3;
  localparam int CTL_XIP = 2;
  localparam int CTL_FIN = 1;
  localparam int CTL_ABT = 0;
  // arming codes
  localparam logic [7:0] ARM_REPLY = 8'h60;
  localparam logic [7:0] ARM_NO_REPLY = 8'h70;
  // id register layout
  localparam int ID_W = 29;
  localparam int ID_EXT_BIT = 31;
  localparam int DLC_W = 4;
  localparam int SLOT_IDX_W = 4;
  localparam int CFG_BASIC_BIT = 0;
  // reset values
  localparam logic [ID_W-1:0] MASK_RST = 29'h1fffffff;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  typedef enum logic {RX_IDLE, RX_WRAP} crs_rx_t;
endpackage

// ### verification/crs_can_model.sv
// can engine model: hands frames to the slots and ends their transmissions
// assumes the bench calls its tasks right after a rising pclk edge
`timescale 1ns/1ns
module crs_can_model import crs_pkg::*; #(
  parameter int TS_W = 16
) (
  // clock and time stamp
  input wire logic pclk,
  input wire logic [TS_W-1:0] ts_count,
  // received frame
  output logic rx_done,
  output logic rx_remote,
  output logic rx_ext,
  output logic [ID_W-1:0] rx_id,
  output logic [DLC_W-1:0] rx_dlc,
  // transmit side
  input wire logic tx_valid,
  output logic tx_intermission,
  output logic tx_done,
  output logic tx_arb_lost,
  output logic tx_bus_err
);
  logic [TS_W-1:0] ts_last;
  initial begin
    {rx_done, rx_remote, rx_ext, rx_id, rx_dlc} = '0;
    {tx_intermission, tx_done, tx_arb_lost, tx_bus_err} = '0;
  end
  // fields valid only with the pulse, scrambled after; pulses two cycles apart
  task automatic frame(input logic rem, input logic ext, input logic [ID_W-1:0] id, input logic [DLC_W-1:0] dlc);
    rx_done <= 1'b1;
    rx_remote <= rem;
    rx_ext <= ext;
    rx_id <= id;
    rx_dlc <= dlc;
    @(posedge pclk);
    ts_last = ts_count;
    rx_done <= 1'b0;
    rx_remote <= ~rem;
    rx_ext <= ~ext;
    rx_id <= ~id;
    rx_dlc <= ~dlc;
    @(posedge pclk);
  endtask
  task automatic gap(output logic seen);
    tx_intermission <= 1'b1;
    @(posedge pclk);
    tx_intermission <= 1'b0;
    seen = 1'b0;
    for (int k = 0; k < 4 && !seen; k++) begin
      @(posedge pclk);
      seen = (tx_valid === 1'b1);
    end
  endtask
  // kind 0 sent, 1 arbitration lost, 2 bus error; lag gives a slow bus
  task automatic outcome(input int kind, input int lag);
    repeat (lag) @(posedge pclk);
    tx_done <= (kind == 0);
    tx_arb_lost <= (kind == 1);
    tx_bus_err <= (kind == 2);
    @(posedge pclk);
    ts_last = ts_count;
    {tx_done, tx_arb_lost, tx_bus_err} <= 3'b000;
    @(posedge pclk);
  endtask
endmodule // crs_can_model

// ### verification/can_remote_frame_receive_slot_bench.sv
// bench for the remote-frame receive slots
// assumes crs_slots with its apb slave and the can engine model
`timescale 1ns/1ns
module can_remote_frame_receive_slot_bench import crs_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_done, rx_remote, rx_ext, tx_int, tx_done, tx_lost, tx_err, tx_valid, tx_ext;
  logic [28:0] rx_id, tx_id;
  logic [3:0] rx_dlc, tx_dlc, tx_slot;
  logic [15:0] ts_count;
  int fails, n_tests;
  crs_slots #(.N(16), .TS_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_done(rx_done), .rx_remote(rx_remote), .rx_ext(rx_ext), .rx_id(rx_id), .rx_dlc(rx_dlc),
    .tx_intermission(tx_int), .tx_done(tx_done), .tx_arb_lost(tx_lost), .tx_bus_err(tx_err),
    .tx_valid(tx_valid), .tx_slot(tx_slot), .tx_id(tx_id), .tx_ext(tx_ext), .tx_dlc(tx_dlc),
    .ts_count(ts_count), .irq(irq));
  crs_can_model #(.TS_W(16)) can (.pclk(pclk), .ts_count(ts_count), .rx_done(rx_done), .rx_remote(rx_remote),
    .rx_ext(rx_ext), .rx_id(rx_id), .rx_dlc(rx_dlc), .tx_valid(tx_valid), .tx_intermission(tx_int),
    .tx_done(tx_done), .tx_arb_lost(tx_lost), .tx_bus_err(tx_err));
  always #5 pclk = ~pclk;
  always @(posedge pclk) ts_count <= ts_count + 16'h0001;
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(what, r & m, exp);
  endtask
  function automatic logic [11:0] sa(input int n, input logic [1:0] r);
    return 12'(n) * SLOT_STRIDE + {8'h00, r, 2'b00};
  endfunction
  task automatic arm(input int n, input logic ext, input logic [28:0] id, input logic [7:0] code);
    wr(sa(n, SLOT_CTRL), 32'h0);
    rd_chk("idle", sa(n, SLOT_CTRL), 32'h4, 32'h0);
    wr(sa(n, SLOT_ID), {ext, 2'b00, id});
    wr(sa(n, SLOT_CTRL), {24'h0, code});
  endtask
  task automatic s_arm;
    arm(3, 1'b0, 29'h55, ARM_REPLY);
    rd_chk("ra reply", sa(3, SLOT_CTRL), 32'hee, 32'h68);
    arm(7, 1'b0, 29'h56, ARM_NO_REPLY);
    rd_chk("ra inhibit", sa(7, SLOT_CTRL), 32'h08, 32'h08);
    rd_chk("unmapped", 12'h1f0, 32'hffffffff, 32'h0);
    chk("slverr", {31'h0, last_err}, 32'h1);
  endtask
  task automatic s_inhibit;
    wr(GLB_INT_EN, 32'h20);
    arm(5, 1'b0, 29'h2a5, ARM_NO_REPLY);
    can.frame(1'b0, 1'b0, 29'h2a5, 4'h6);
    rd_chk("data frame", sa(5, SLOT_CTRL), 32'hee, 32'h68);
    can.frame(1'b1, 1'b0, 29'h2a5, 4'h6);
    rd_chk("inactive", sa(5, SLOT_CTRL), 32'hee, 32'h0);
    rd_chk("id", sa(5, SLOT_ID), 32'h800007ff, 32'h2a5);
    rd_chk("dlc", sa(5, SLOT_DLC), 32'hf, 32'h6);
    rd_chk("stamp", sa(5, SLOT_TS), 32'hffff, {16'h0, can.ts_last});
    rd_chk("status", GLB_INT_STAT, 32'h20, 32'h20);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(GLB_INT_STAT, 32'h20);
    can.frame(1'b1, 1'b0, 29'h2a5, 4'h6);
    rd_chk("stays off", GLB_INT_STAT, 32'h20, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
  endtask
  task automatic s_filter;
    arm(0, 1'b1, 29'h1f0, ARM_NO_REPLY);
    arm(1, 1'b0, 29'h1f0, ARM_NO_REPLY);
    arm(2, 1'b0, 29'h1f0, ARM_NO_REPLY);
    wr(GLB_MASK, 32'h1ffffffe);
    can.frame(1'b1, 1'b0, 29'h1f1, 4'h2);
    rd_chk("ext differs", sa(0, SLOT_CTRL), 32'h08, 32'h08);
    rd_chk("lowest", GLB_INT_STAT, 32'h7, 32'h2);
    rd_chk("masked id", sa(1, SLOT_ID), 32'h800007ff, 32'h1f1);
    wr(GLB_MASK, {3'h0, MASK_RST});
    can.frame(1'b1, 1'b0, 29'h1f1, 4'h2);
    rd_chk("no match", GLB_INT_STAT, 32'h7, 32'h2);
    rd_chk("untouched", sa(2, SLOT_CTRL), 32'hee, 32'h68);
    can.frame(1'b1, 1'b1, 29'h1f0, 4'h2);
    rd_chk("ext match", GLB_INT_STAT, 32'h7, 32'h3);
    wr(GLB_INT_STAT, 32'hffff);
  endtask
  task automatic s_reply;
    wr(GLB_INT_EN, 32'h10);
    arm(4, 1'b0, 29'h123, ARM_REPLY);
    arm(6, 1'b1, 29'h1abcdef, ARM_REPLY);
    can.frame(1'b1, 1'b1, 29'h1abcdef, 4'h8);
    can.frame(1'b1, 1'b0, 29'h123, 4'h3);
    rd_chk("to transmit", sa(4, SLOT_CTRL), 32'hee, 32'h80);
    wr(GLB_INT_STAT, 32'hffff);
    can.gap(seen);
    chk("lowest tx", {27'h0, seen, tx_slot}, 32'h14);
    chk("reply id", {tx_ext, 2'h0, tx_id}, 32'h123);
    chk("reply dlc", {28'h0, tx_dlc}, 32'h3);
    can.outcome(1, 0);
    rd_chk("arb lost", sa(4, SLOT_CTRL), 32'h84, 32'h80);
    can.gap(seen);
    chk("retry", {27'h0, seen, tx_slot}, 32'h14);
    can.outcome(0, 5);
    rd_chk("done ctrl", sa(4, SLOT_CTRL), 32'hee, 32'h02);
    rd_chk("done stamp", sa(4, SLOT_TS), 32'hffff, {16'h0, can.ts_last});
    rd_chk("done status", GLB_INT_STAT, 32'h10, 32'h10);
    chk("done irq", {31'h0, irq}, 32'h1);
    can.gap(seen);
    chk("next slot", {27'h0, seen, tx_slot}, 32'h16);
    chk("ext reply", {tx_ext, 2'h0, tx_id}, {1'b1, 2'h0, 29'h1abcdef});
    wr(sa(6, SLOT_CTRL), 32'h1);
    can.outcome(2, 2);
    rd_chk("abort", sa(6, SLOT_CTRL), 32'hff, 32'h0);
    can.gap(seen);
    chk("no resend", {31'h0, seen}, 32'h0);
  endtask
  task automatic s_basic;
    wr(GLB_CFG, 32'h1);
    arm(14, 1'b0, 29'h3c, ARM_REPLY);
    can.frame(1'b1, 1'b0, 29'h3c, 4'h1);
    rd_chk("basic rx", GLB_INT_STAT, 32'h4000, 32'h4000);
    can.gap(seen);
    chk("basic quiet", {31'h0, seen}, 32'h0);
    wr(sa(15, SLOT_CTRL), 32'h80);
    can.gap(seen);
    chk("basic tx", {31'h0, seen}, 32'h0);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ts_count, last_err} = '0;
    fails = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_arm();
    s_inhibit();
    s_filter();
    s_reply();
    s_basic();
    test_done();
  end
endmodule // can_remote_frame_receive_slot_bench
